// >>> irrx_ctrl.v
// Infrared receive control register with excess-low and max-bit-cycle detection and interrupts.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "irrx_defines.vh"

module irrx_ctrl (
  // Clock and reset.
  input wire clk_sys_in,
  input wire rst_in,
  // Register port.
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [31:0] rdata_out,
  // Remote control input pin.
  input wire ir_pin_in,
  // Thresholds held in neighbouring registers.
  input wire [7:0] leader_cycle_min_in,
  input wire [7:0] leader_cycle_max_in,
  input wire [6:0] data_threshold_in,
  input wire [6:0] phase_upper_threshold_in,
  // Decoded data and reception state.
  output wire bit_valid_out,
  output wire bit_value_out,
  output wire [1:0] phase_pattern_out,
  output wire receiving_out,
  output wire rx_done_out,
  // Interrupt.
  output wire irq_out
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_FIRST = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam CNT_W = 11;
  localparam [CNT_W-1:0] CNT_MAX = 11'h7FF;
  localparam [31:0] SAMPLE_CYC = `IRRX_SAMPLE_CYCLES;

  reg [31:0] ctrl2_reg;
  reg [`IRRX_ST_WIDTH-1:0] status_reg;
  reg [`IRRX_ST_WIDTH-1:0] mask_reg;
  reg [31:0] rdata_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CNT_W-1:0] low_cnt_reg;
  reg [CNT_W-1:0] cyc_cnt_reg;
  reg bit_valid_reg;
  reg bit_value_reg;
  reg [1:0] pattern_reg;
  reg done_reg;
  reg bit_valid_next;
  reg bit_value_next;
  reg [1:0] pattern_next;
  reg leader_evt;
  reg low_evt;
  reg dmax_evt;
  reg [`IRRX_ST_WIDTH-1:0] evt_vec;
  reg [31:0] rd_mux;

  wire ir_level;
  wire ir_fall;
  wire leader_irq_en = ctrl2_reg[`IRRX_BIT_LEADER_IRQ_EN];
  wire edge_irq_en = ctrl2_reg[`IRRX_BIT_EDGE_IRQ_EN];
  wire leader_opt = ctrl2_reg[`IRRX_BIT_LEADER_OPT];
  wire phase_sel = ctrl2_reg[`IRRX_BIT_PHASE_SEL];
  wire [7:0] low_thr = ctrl2_reg[`IRRX_LOW_MSB:`IRRX_LOW_LSB];
  wire [7:0] dmax_thr = ctrl2_reg[`IRRX_DMAX_MSB:`IRRX_DMAX_LSB];
  wire wr_ctrl = wr_in && (addr_in == `IRRX_OFS_CTRL2);
  wire wr_status = wr_in && (addr_in == `IRRX_OFS_STATUS);
  wire wr_mask = wr_in && (addr_in == `IRRX_OFS_MASK);
  wire [CNT_W-1:0] lead_min = {1'b0, leader_cycle_min_in, 2'b00};
  wire [CNT_W-1:0] lead_max = {1'b0, leader_cycle_max_in, 2'b00};
  wire leader_on = (leader_cycle_max_in != 8'h00);

  // ****************************************
  // Helper functions
  // ****************************************

  // True when a count has passed a threshold that is not the all-ones off code.
  function over_limit;
    input [CNT_W-1:0] cnt;
    input [7:0] thr;
    begin
      over_limit = (thr != `IRRX_THR_OFF) && (cnt > {3'b000, thr} * SAMPLE_CYC[CNT_W-1:0]);
    end
  endfunction

  // Saturating increment of a width counter.
  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] cnt;
    begin
      sat_inc = (cnt == CNT_MAX) ? cnt : cnt + 11'd1;
    end
  endfunction

  // ****************************************
  // Input synchronisation
  // ****************************************
  irrx_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(ir_pin_in),
    .level_out(ir_level),
    .fall_out(ir_fall)
  );

  // ****************************************
  // Receive sequencer
  // ****************************************

  // Next state, bit decisions and events for one sampling period.
  always @* begin
    state_next = state_reg;
    bit_valid_next = 1'b0;
    bit_value_next = bit_value_reg;
    pattern_next = pattern_reg;
    leader_evt = 1'b0;
    low_evt = 1'b0;
    dmax_evt = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (ir_fall) begin
          state_next = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (ir_fall) begin
          if (!leader_on) begin
            state_next = ST_DATA;
            bit_valid_next = 1'b1;
          end else if (cyc_cnt_reg > lead_min && cyc_cnt_reg <= lead_max) begin
            state_next = ST_DATA;
            leader_evt = 1'b1;
          end else if (cyc_cnt_reg <= lead_min && leader_opt) begin
            state_next = ST_DATA;
            bit_valid_next = 1'b1;
          end else begin
            state_next = ST_FIRST;
          end
        end
      end
      ST_DATA: begin
        if (ir_fall) begin
          bit_valid_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Decode the just-finished cycle as a data bit.
    if (bit_valid_next) begin
      if (phase_sel) begin
        // Phase method patterns from both thresholds.
        if (cyc_cnt_reg > {4'h0, phase_upper_threshold_in}) begin
          pattern_next = 2'b10;
        end else if (cyc_cnt_reg > {4'h0, data_threshold_in}) begin
          pattern_next = 2'b01;
        end else begin
          pattern_next = 2'b00;
        end
        bit_value_next = pattern_next[1];
      end else begin
        // Cycle method compares against the data threshold only.
        bit_value_next = (cyc_cnt_reg > {4'h0, data_threshold_in});
        pattern_next = 2'b00;
      end
    end
    // Timeouts while a frame is in progress end the reception.
    if (state_reg != ST_IDLE) begin
      if (!ir_level && over_limit(low_cnt_reg, low_thr)) begin
        low_evt = 1'b1;
      end
      if (state_reg == ST_DATA && over_limit(cyc_cnt_reg, dmax_thr)) begin
        dmax_evt = 1'b1;
      end
      if (low_evt || dmax_evt) begin
        state_next = ST_IDLE;
        bit_valid_next = 1'b0;
      end
    end
  end

  // State, counters and decoded outputs.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      low_cnt_reg <= 11'h000;
      cyc_cnt_reg <= 11'h000;
      bit_valid_reg <= 1'b0;
      bit_value_reg <= 1'b0;
      pattern_reg <= 2'b00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_valid_reg <= bit_valid_next;
      bit_value_reg <= bit_value_next;
      pattern_reg <= pattern_next;
      done_reg <= low_evt | dmax_evt;
      // Cycle counter restarts on every falling edge.
      if (ir_fall || state_next == ST_IDLE) begin
        cyc_cnt_reg <= 11'h001;
      end else begin
        cyc_cnt_reg <= sat_inc(cyc_cnt_reg);
      end
      // Low width counter runs only while the line is low.
      if (ir_level || state_next == ST_IDLE) begin
        low_cnt_reg <= 11'h000;
      end else begin
        low_cnt_reg <= sat_inc(low_cnt_reg);
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************

  // Events that may set status; enables gate leader and edge events.
  always @* begin
    evt_vec = 4'h0;
    evt_vec[`IRRX_ST_LEADER] = leader_evt & leader_irq_en;
    evt_vec[`IRRX_ST_EDGE] = ir_fall & edge_irq_en;
    evt_vec[`IRRX_ST_LOW] = low_evt;
    evt_vec[`IRRX_ST_DMAX] = dmax_evt;
  end

  // Control, status and mask registers; a new event wins over a clear.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl2_reg <= `IRRX_CTRL2_RESET;
      status_reg <= `IRRX_STATUS_RESET;
      mask_reg <= `IRRX_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl2_reg <= wdata_in & `IRRX_CTRL2_WMASK;
      end
      if (wr_mask) begin
        mask_reg <= wdata_in[`IRRX_ST_WIDTH-1:0];
      end
      if (wr_status) begin
        status_reg <= (status_reg & ~wdata_in[`IRRX_ST_WIDTH-1:0]) | evt_vec;
      end else begin
        status_reg <= status_reg | evt_vec;
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always @* begin
    if (addr_in == `IRRX_OFS_CTRL2) begin
      rd_mux = ctrl2_reg;
    end else if (addr_in == `IRRX_OFS_STATUS) begin
      rd_mux = {28'h000_0000, status_reg};
    end else if (addr_in == `IRRX_OFS_MASK) begin
      rd_mux = {28'h000_0000, mask_reg};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_in) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_out = rdata_reg;
  assign bit_valid_out = bit_valid_reg;
  assign bit_value_out = bit_value_reg;
  assign phase_pattern_out = pattern_reg;
  assign receiving_out = (state_reg != ST_IDLE);
  assign rx_done_out = done_reg;
  assign irq_out = |(status_reg & mask_reg);

endmodule // irrx_ctrl

`default_nettype wire

// >>> irrx_defines.vh
// Constants of the infrared receive control block: offsets, field positions, reset values, timing.
`ifndef IRRX_DEFINES_VH
`define IRRX_DEFINES_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define IRRX_OFS_CTRL2 8'h00
`define IRRX_OFS_STATUS 8'h04
`define IRRX_OFS_MASK 8'h08

// ****************************************
// Control register fields
// ****************************************
`define IRRX_BIT_LEADER_IRQ_EN 31
`define IRRX_BIT_EDGE_IRQ_EN 30
`define IRRX_BIT_LEADER_OPT 25
`define IRRX_BIT_PHASE_SEL 24
`define IRRX_LOW_MSB 15
`define IRRX_LOW_LSB 8
`define IRRX_DMAX_MSB 7
`define IRRX_DMAX_LSB 0
`define IRRX_CTRL2_RESET 32'h0000_FFFF
`define IRRX_CTRL2_WMASK 32'hC300_FFFF
`define IRRX_THR_OFF 8'hFF

// ****************************************
// Status and mask fields
// ****************************************
`define IRRX_ST_EDGE 0
`define IRRX_ST_DMAX 1
`define IRRX_ST_LOW 2
`define IRRX_ST_LEADER 3
`define IRRX_ST_WIDTH 4
`define IRRX_STATUS_RESET 4'h0
`define IRRX_MASK_RESET 4'hF

// ****************************************
// Timing
// ****************************************
`define IRRX_SAMPLE_PERIOD_NS 100
`define IRRX_SYS_PERIOD_NS 100
`define IRRX_SAMPLE_CYCLES (`IRRX_SAMPLE_PERIOD_NS / `IRRX_SYS_PERIOD_NS)
`define IRRX_LEADER_SCALE 4

`endif

// >>> irrx_sync.v
// Two-stage synchroniser for the remote control input with falling-edge pulse.
`timescale 1ns/100ps
`default_nettype none

module irrx_sync (
  // Clock and reset.
  input wire clk_sys_in,
  input wire rst_in,
  // Asynchronous pin and synchronised results.
  input wire pin_in,
  output wire level_out,
  output wire fall_out
);

  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // The first stage feeds only the second; edges are found behind the second stage.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Level and one-cycle falling-edge pulse.
  assign level_out = sync_reg;
  assign fall_out = prev_reg & ~sync_reg;

endmodule // irrx_sync

`default_nettype wire

// >>> irrx_chk.sv
// Concurrent checks on the ports of the infrared receive control block.
`timescale 1ns/100ps
`default_nettype none
module irrx_chk (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port.
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // Receiver outputs.
  input wire logic bit_valid_out,
  input wire logic [1:0] phase_pattern_out,
  input wire logic receiving_out,
  input wire logic rx_done_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  logic [31:0] c_reg;
  logic [3:0] m_reg;
  // Shadow copies of the control and mask registers, kept from the writes.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      c_reg <= 32'h0000_FFFF;
      m_reg <= 4'hF;
    end else if (wr_in && addr_in == 8'h00) begin
      c_reg <= wdata_in & 32'hC300_FFFF;
    end else if (wr_in && addr_in == 8'h08) begin
      m_reg <= wdata_in[3:0];
    end
  end
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000) else $error("read data not idle");
  a_ctrl_read: assert property ($past(rd_in) && $past(addr_in) == 8'h00 |-> rdata_out == c_reg)
    else $error("control read mismatch");
  a_done_single: assert property (rx_done_out |=> !rx_done_out) else $error("done pulse too long");
  a_done_ends_rx: assert property (rx_done_out |-> ##[0:2] !receiving_out) else $error("reception not ended");
  a_done_irq: assert property (rx_done_out && m_reg[2:1] == 2'b11 |-> ##[0:2] irq_out)
    else $error("no interrupt on end of reception");
  a_thr_off: assert property (c_reg[15:0] == 16'hFFFF && $past(c_reg[15:0]) == 16'hFFFF |-> !rx_done_out)
    else $error("end of reception with detection off");
  a_cycle_pattern: assert property (bit_valid_out && !c_reg[24] |-> phase_pattern_out == 2'b00)
    else $error("phase pattern in cycle method");
  a_bit_single: assert property (bit_valid_out |=> !bit_valid_out) else $error("bit pulse too long");
  a_mask_off: assert property (wr_in && addr_in == 8'h08 && wdata_in[3:0] == 4'h0 |=> !irq_out)
    else $error("interrupt while masked");
  c_done: cover property (rx_done_out);
  c_bit: cover property (bit_valid_out);
  c_irq: cover property ($rose(irq_out));
endmodule // irrx_chk
bind irrx_ctrl irrx_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .bit_valid_out(bit_valid_out),
  .phase_pattern_out(phase_pattern_out), .receiving_out(receiving_out), .rx_done_out(rx_done_out), .irq_out(irq_out));
`default_nettype wire

// >>> irrx_ir_src.sv
// Behavioural remote control transmitter: one low then high pulse per request.
`timescale 1ns/100ps
`default_nettype none
module irrx_ir_src (
  // Clock.
  input wire logic clk_sys_in,
  // Pulse request with low and high widths in clocks.
  input wire logic go_in,
  input wire logic [10:0] low_in,
  input wire logic [10:0] high_in,
  // Line, idle high, and activity flag.
  output logic pin_out,
  output logic busy_out
);
  // Line rests high between pulses, as a pulled-up receiver input would.
  initial begin
    pin_out = 1'b1;
    busy_out = 1'b0;
  end
  // Each request gives one falling edge; a bit cycle is low plus high plus the clocks until the next request is taken.
  always begin
    @(posedge clk_sys_in);
    if (go_in) begin
      busy_out <= 1'b1;
      pin_out <= 1'b0;
      repeat (low_in) @(posedge clk_sys_in);
      pin_out <= 1'b1;
      repeat (high_in) @(posedge clk_sys_in);
      busy_out <= 1'b0;
    end
  end
endmodule // irrx_ir_src
`default_nettype wire

// >>> test_ir_rx_mode_timeout_control.sv
// Self-checking testbench of the infrared receive control block.
`timescale 1ns/100ps
`default_nettype none
module test_ir_rx_mode_timeout_control;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] lmin = 8'h00;
  logic [7:0] lmax = 8'h00;
  logic go = 1'b0;
  logic [10:0] lo = 11'h000;
  logic [10:0] hi = 11'h000;
  logic [1:0] bits = 2'b00;
  logic [5:0] pats = 6'h00;
  int nbits = 0;
  int b0 = 0;
  wire [31:0] rdata_out;
  wire [1:0] pat;
  wire ir_pin, busy, bit_valid_out, bit_value_out, receiving_out, rx_done_out, irq_out;
  int n_errors = 0;
  int check_count = 0;
  int dones = 0;
  int d0 = 0;
  // Clock at 100 ns.
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Counts end-of-reception pulses and shifts in decoded bits.
  always @(posedge clk_sys_in) begin
    if (rx_done_out === 1'b1) dones <= dones + 1;
    if (bit_valid_out === 1'b1) bits <= {bits[0], bit_value_out};
    if (bit_valid_out === 1'b1) pats <= {pats[3:0], pat};
    if (bit_valid_out === 1'b1) nbits <= nbits + 1;
  end
  irrx_ctrl DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .ir_pin_in(ir_pin), .leader_cycle_min_in(lmin), .leader_cycle_max_in(lmax),
    .data_threshold_in(7'h0F), .phase_upper_threshold_in(7'h20), .bit_valid_out(bit_valid_out),
    .bit_value_out(bit_value_out), .phase_pattern_out(pat), .receiving_out(receiving_out),
    .rx_done_out(rx_done_out), .irq_out(irq_out));
  irrx_ir_src u_src (.clk_sys_in(clk_sys_in), .go_in(go), .low_in(lo), .high_in(hi), .pin_out(ir_pin), .busy_out(busy));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys_in);
    {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task rd(input string nm, input [7:0] a, input [31:0] e);
    @(posedge clk_sys_in);
    {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk(nm, e, rdata_out);
  endtask
  task pulse(input [10:0] l, input [10:0] h);
    @(posedge clk_sys_in);
    {go, lo, hi} <= {1'b1, l, h};
    @(posedge clk_sys_in);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk_sys_in);
  endtask
  task expect_done(input string nm, input int n, input int span);
    for (int i = 0; i < span && dones == d0; i++) @(posedge clk_sys_in);
    #1 chk(nm, n, dones - d0);
  endtask
  // Reset values, reserved bits and an unmapped address.
  task t_regs;
    rd("ctrl_reset", 8'h00, 32'h0000_FFFF);
    rd("mask_reset", 8'h08, 32'h0000_000F);
    wr(8'h00, 32'hFFFF_FFFF);
    rd("ctrl_rw", 8'h00, 32'hC300_FFFF);
    rd("unmapped", 8'h40, 32'h0000_0000);
  endtask
  // Falling edge interrupt enabled gives the edge status bit.
  task t_edge;
    wr(8'h00, 32'h4000_FFFF);
    pulse(11'h005, 11'h005);
    rd("edge_status", 8'h04, 32'h0000_0001);
    wr(8'h04, 32'h0000_000F);
  endtask
  // Excess low width ends reception, raises the interrupt, cleared by writing one.
  task t_low;
    wr(8'h00, 32'h0000_14FF);
    d0 = dones;
    pulse(11'h028, 11'h005);
    expect_done("low_done", 1, 100);
    chk("low_rx_end", 0, receiving_out);
    rd("low_status", 8'h04, 32'h0000_0004);
    chk("low_irq", 1, irq_out);
    wr(8'h04, 32'h0000_000F);
    #1 chk("irq_clear", 0, irq_out);
  endtask
  // Phase method: cycles of 13, 28 and 43 clocks fall below, between and above both thresholds.
  task t_phase;
    wr(8'h00, 32'h0100_FF3C);
    d0 = dones;
    pulse(11'h005, 11'h005);
    pulse(11'h005, 11'h014);
    pulse(11'h005, 11'h023);
    pulse(11'h005, 11'h005);
    expect_done("phase_done", 1, 200);
    chk("phase_pats", 6'h06, pats);
    chk("phase_bits", 2'b01, bits);
    wr(8'h04, 32'h0000_000F);
  endtask
  // Leader optional: a first cycle below the leader minimum is kept as a data bit.
  task t_opt;
    lmin <= 8'h08;
    lmax <= 8'h0A;
    wr(8'h00, 32'h8200_FF3C);
    d0 = dones;
    b0 = nbits;
    pulse(11'h005, 11'h005);
    pulse(11'h005, 11'h005);
    pulse(11'h005, 11'h005);
    expect_done("opt_done", 1, 200);
    chk("opt_bits", 2, nbits - b0);
    rd("opt_status", 8'h04, 32'h0000_0002);
    wr(8'h04, 32'h0000_000F);
    lmax <= 8'h00;
  endtask
  // Maximum bit cycle ends reception; interrupt masked, then unmasked.
  task t_dmax;
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_FF1E);
    d0 = dones;
    pulse(11'h005, 11'h005);
    pulse(11'h005, 11'h014);
    pulse(11'h005, 11'h005);
    expect_done("dmax_done", 1, 200);
    chk("bits", 2'b01, bits);
    rd("dmax_status", 8'h04, 32'h0000_0002);
    chk("irq_masked", 0, irq_out);
    wr(8'h08, 32'h0000_000F);
    #1 chk("irq_unmasked", 1, irq_out);
    wr(8'h04, 32'h0000_000F);
  endtask
  // Leader within limits with its interrupt enabled.
  task t_leader;
    lmin <= 8'h02;
    lmax <= 8'h0A;
    wr(8'h00, 32'h8000_FF1E);
    d0 = dones;
    pulse(11'h00A, 11'h00F);
    pulse(11'h005, 11'h005);
    expect_done("leader_done", 1, 200);
    rd("leader_status", 8'h04, 32'h0000_000A);
    wr(8'h04, 32'h0000_000F);
    lmax <= 8'h00;
  endtask
  // All-ones thresholds switch both detections off.
  task t_off;
    wr(8'h00, 32'h0000_FFFF);
    d0 = dones;
    pulse(11'h005, 11'h005);
    pulse(11'h005, 11'h005);
    pulse(11'h12C, 11'h005);
    expect_done("off_done", 0, 300);
    rd("off_status", 8'h04, 32'h0000_0000);
  endtask
  task report_and_stop;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_regs;
    t_edge;
    t_low;
    t_phase;
    t_dmax;
    t_leader;
    t_opt;
    t_off;
    report_and_stop;
  end
  // Watchdog, well beyond the thousand or so cycles the sequence needs.
  initial begin
    #2000000;
    n_errors++;
    report_and_stop;
  end
endmodule // test_ir_rx_mode_timeout_control
`default_nettype wire
